// *** hw/wake_pkg.sv ***
package wake_pkg;
  localparam int             ADDR_W           = 48;
  localparam int             IP_W             = 128;
  localparam int             MCAST_BIT        = 40;
  localparam logic [47:0]    BCAST_ADDR       = 48'hffff_ffff_ffff;
  localparam logic [127:0]   FORCE_MATCH      = 128'h0;
  localparam logic [1:0]     SLEEP_LEVEL_ZERO = 2'h0;
  localparam logic [1:0]     SLEEP_LEVEL_ONE  = 2'h1;
  localparam logic [1:0]     SLEEP_LEVEL_THREE = 2'h3;
  localparam int             NUM_FLAGS        = 9;
  localparam int             FLG_BCAST        = 0;
  localparam int             FLG_EXACT        = 1;
  localparam int             FLG_V4           = 2;
  localparam int             FLG_V6           = 3;
  localparam int             FLG_PATTERN      = 4;
  localparam int             FLG_MAGIC        = 5;
  localparam int             FLG_LINK_UP      = 6;
  localparam int             FLG_LINK_DOWN    = 7;
  localparam int             FLG_PIN          = 8;
  localparam logic [8:0]     FLAGS_RESET      = 9'h000;

  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_SLEEP = 2'h1,
    ST_WOKEN = 2'h3
  } mode_type;

  // zero in the compare register means match anything
  function automatic logic compare_field(input logic [127:0] want, input logic [127:0] got);
    compare_field = (want == FORCE_MATCH) || (want == got);
  endfunction

  function automatic logic monitored_level(input logic [1:0] level);
    monitored_level = (level == SLEEP_LEVEL_ZERO) || (level == SLEEP_LEVEL_ONE) ||
                      (level == SLEEP_LEVEL_THREE);
  endfunction
endpackage

// *** hw/wake_frame_if.sv ***
`timescale 1ns/1ps
interface wake_frame_if;
  logic         frame_done;
  logic [47:0]  dest_addr;
  logic [47:0]  station_addr;
  logic         is_ipv4;
  logic         is_ipv6;
  logic         is_tcp;
  logic         tcp_syn;
  logic [127:0] ip_src;
  logic [127:0] ip_dst;
  logic [15:0]  src_port;
  logic [15:0]  dst_port;
  logic         ip_hdr_csum_ok;
  logic         tcp_csum_ok;
  logic         fcs_ok;
  logic         pattern_hit;
  logic         magic_hit;
  logic [31:0]  v4_src_cmp;
  logic [31:0]  v4_dst_cmp;
  logic [31:0]  v4_port_cmp;
  logic [127:0] v6_src_cmp;
  logic [127:0] v6_dst_cmp;
  logic [31:0]  v6_port_cmp;
  logic         hit_valid;
  logic         hit_bcast;
  logic         hit_exact;
  logic         hit_v4;
  logic         hit_v6;
  logic         hit_pattern;
  logic         hit_magic;
  logic         hit_fcs_ok;

  modport feed (
    output frame_done, dest_addr, station_addr, is_ipv4, is_ipv6, is_tcp, tcp_syn,
    output ip_src, ip_dst, src_port, dst_port, ip_hdr_csum_ok, tcp_csum_ok, fcs_ok,
    output pattern_hit, magic_hit, v4_src_cmp, v4_dst_cmp, v4_port_cmp,
    output v6_src_cmp, v6_dst_cmp, v6_port_cmp,
    input  hit_valid, hit_bcast, hit_exact, hit_v4, hit_v6, hit_pattern, hit_magic, hit_fcs_ok
  );
  modport check (
    input  frame_done, dest_addr, station_addr, is_ipv4, is_ipv6, is_tcp, tcp_syn,
    input  ip_src, ip_dst, src_port, dst_port, ip_hdr_csum_ok, tcp_csum_ok, fcs_ok,
    input  pattern_hit, magic_hit, v4_src_cmp, v4_dst_cmp, v4_port_cmp,
    input  v6_src_cmp, v6_dst_cmp, v6_port_cmp,
    output hit_valid, hit_bcast, hit_exact, hit_v4, hit_v6, hit_pattern, hit_magic, hit_fcs_ok
  );
endinterface

// *** hw/wake_frame_qualifier.sv ***
`timescale 1ns/1ps
module wake_frame_qualifier (
  input wire logic clk,
  input wire logic rst_n,
  wake_frame_if.check f
);
  typedef struct packed {
    logic valid;
    logic bcast;
    logic exact;
    logic v4;
    logic v6;
    logic pattern;
    logic magic;
    logic fcs_ok;
  } qual_state_type;

  qual_state_type cur_reg;
  qual_state_type cur_next;

  always_comb
  begin
    logic addr_ok;
    logic ports_v4;
    logic ports_v6;
    addr_ok  = 1'b0;
    ports_v4 = 1'b0;
    ports_v6 = 1'b0;
    cur_next = '0;
    // own, multicast or broadcast destination only
    addr_ok = (f.dest_addr == f.station_addr) || f.dest_addr[wake_pkg::MCAST_BIT] ||
              (f.dest_addr == wake_pkg::BCAST_ADDR);
    ports_v4 = wake_pkg::compare_field({112'h0, f.v4_port_cmp[31:16]}, {112'h0, f.src_port}) &&
               wake_pkg::compare_field({112'h0, f.v4_port_cmp[15:0]}, {112'h0, f.dst_port});
    ports_v6 = wake_pkg::compare_field({112'h0, f.v6_port_cmp[31:16]}, {112'h0, f.src_port}) &&
               wake_pkg::compare_field({112'h0, f.v6_port_cmp[15:0]}, {112'h0, f.dst_port});
    cur_next.valid   = f.frame_done;
    cur_next.fcs_ok  = f.frame_done && f.fcs_ok;
    // bad fcs clears every hit; only valid still marks the frame
    cur_next.bcast   = cur_next.fcs_ok && (f.dest_addr == wake_pkg::BCAST_ADDR);
    cur_next.exact   = cur_next.fcs_ok && (f.dest_addr == f.station_addr);
    cur_next.pattern = cur_next.fcs_ok && f.pattern_hit;
    cur_next.magic   = cur_next.fcs_ok && f.magic_hit;
    cur_next.v4 = cur_next.fcs_ok && addr_ok && f.is_ipv4 && f.is_tcp && f.tcp_syn &&
                  f.ip_hdr_csum_ok && f.tcp_csum_ok && ports_v4 &&
                  wake_pkg::compare_field({96'h0, f.v4_src_cmp}, {96'h0, f.ip_src[31:0]}) &&
                  wake_pkg::compare_field({96'h0, f.v4_dst_cmp}, {96'h0, f.ip_dst[31:0]});
    // is_tcp covers tcp found in the base or an extension header
    cur_next.v6 = cur_next.fcs_ok && addr_ok && f.is_ipv6 && f.is_tcp && f.tcp_syn &&
                  f.tcp_csum_ok && ports_v6 &&
                  wake_pkg::compare_field(f.v6_src_cmp, f.ip_src) &&
                  wake_pkg::compare_field(f.v6_dst_cmp, f.ip_dst);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cur_reg <= '0;
    else
      cur_reg <= cur_next;
  end

  assign f.hit_valid   = cur_reg.valid;
  assign f.hit_bcast   = cur_reg.bcast;
  assign f.hit_exact   = cur_reg.exact;
  assign f.hit_v4      = cur_reg.v4;
  assign f.hit_v6      = cur_reg.v6;
  assign f.hit_pattern = cur_reg.pattern;
  assign f.hit_magic   = cur_reg.magic;
  assign f.hit_fcs_ok  = cur_reg.fcs_ok;

  v4_checks_a: assert property (@(posedge clk) disable iff (!rst_n)
    cur_reg.v4 |-> $past(f.ip_hdr_csum_ok && f.tcp_csum_ok && f.fcs_ok))
    else $error("v4 hit without good checksums");
  v4_syn_a: assert property (@(posedge clk) disable iff (!rst_n)
    cur_reg.v4 |-> $past(f.is_ipv4 && f.is_tcp && f.tcp_syn))
    else $error("v4 hit without tcp syn");
  v6_checks_a: assert property (@(posedge clk) disable iff (!rst_n)
    cur_reg.v6 |-> $past(f.tcp_csum_ok && f.fcs_ok && f.is_ipv6))
    else $error("v6 hit without good checksums");
endmodule // wake_frame_qualifier

// *** hw/wake_event_detector.sv ***
`timescale 1ns/1ps
module wake_event_detector (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [1:0]   sleep_level,
  input  wire logic         suspend_request,
  input  wire logic         resume_request,
  input  wire logic         store_wake_frame,
  input  wire logic         broadcast_wake_enable,
  input  wire logic         v4_syn_wake_enable,
  input  wire logic         v6_syn_wake_enable,
  input  wire logic [5:0]   other_wake_enable,
  input  wire logic [8:0]   flag_clear,
  input  wire logic [15:0]  station_addr_upper,
  input  wire logic [31:0]  station_addr_lower,
  input  wire logic [31:0]  v4_syn_src_compare,
  input  wire logic [31:0]  v4_syn_dst_compare,
  input  wire logic [31:0]  v4_syn_port_compare,
  input  wire logic [127:0] v6_syn_src_compare,
  input  wire logic [127:0] v6_syn_dst_compare,
  input  wire logic [31:0]  v6_syn_port_compare,
  input  wire logic         rx_frame_done,
  input  wire logic [47:0]  rx_dest_addr,
  input  wire logic         rx_is_ipv4,
  input  wire logic         rx_is_ipv6,
  input  wire logic         rx_is_tcp,
  input  wire logic         rx_tcp_syn,
  input  wire logic [127:0] rx_ip_src,
  input  wire logic [127:0] rx_ip_dst,
  input  wire logic [15:0]  rx_src_port,
  input  wire logic [15:0]  rx_dst_port,
  input  wire logic         rx_ip_hdr_csum_ok,
  input  wire logic         rx_tcp_csum_ok,
  input  wire logic         rx_fcs_ok,
  input  wire logic         rx_pattern_hit,
  input  wire logic         rx_magic_hit,
  input  wire logic         link_up_event,
  input  wire logic         link_down_event,
  input  wire logic         wake_pin,
  output logic              broadcast_seen_flag,
  output logic              exact_dest_seen_flag,
  output logic              v4_syn_seen_flag,
  output logic              v6_syn_seen_flag,
  output logic [4:0]        other_seen_flags,
  output logic              remote_wakeup,
  output logic              full_operation,
  output logic              normal_rx_enable,
  output logic              frame_keep_valid,
  output logic              frame_keep
);
  typedef struct packed {
    wake_pkg::mode_type mode;
    logic [8:0]         flags;
    logic               pin_meta;
    logic               pin_sync;
    logic               pin_last;
    logic               remote_wakeup;
    logic               normal_rx;
    logic               full_op;
    logic               keep_valid;
    logic               keep;
  } top_state_type;

  top_state_type cur_reg;
  top_state_type cur_next;
  logic [8:0]    enables;
  logic [8:0]    hits;
  logic [8:0]    fire;

  wake_frame_if fi ();

  assign fi.frame_done     = rx_frame_done;
  assign fi.dest_addr      = rx_dest_addr;
  assign fi.station_addr   = {station_addr_upper, station_addr_lower};
  assign fi.is_ipv4        = rx_is_ipv4;
  assign fi.is_ipv6        = rx_is_ipv6;
  assign fi.is_tcp         = rx_is_tcp;
  assign fi.tcp_syn        = rx_tcp_syn;
  assign fi.ip_src         = rx_ip_src;
  assign fi.ip_dst         = rx_ip_dst;
  assign fi.src_port       = rx_src_port;
  assign fi.dst_port       = rx_dst_port;
  assign fi.ip_hdr_csum_ok = rx_ip_hdr_csum_ok;
  assign fi.tcp_csum_ok    = rx_tcp_csum_ok;
  assign fi.fcs_ok         = rx_fcs_ok;
  assign fi.pattern_hit    = rx_pattern_hit;
  assign fi.magic_hit      = rx_magic_hit;
  assign fi.v4_src_cmp     = v4_syn_src_compare;
  assign fi.v4_dst_cmp     = v4_syn_dst_compare;
  assign fi.v4_port_cmp    = v4_syn_port_compare;
  assign fi.v6_src_cmp     = v6_syn_src_compare;
  assign fi.v6_dst_cmp     = v6_syn_dst_compare;
  assign fi.v6_port_cmp    = v6_syn_port_compare;

  wake_frame_qualifier u_qual (
    .clk   (clk),
    .rst_n (rst_n),
    .f     (fi.check)
  );

  // order follows the flag index constants
  assign enables = {other_wake_enable[5:1], v6_syn_wake_enable, v4_syn_wake_enable,
                    other_wake_enable[0], broadcast_wake_enable};

  always_comb
  begin
    hits = '0;
    hits[wake_pkg::FLG_BCAST]     = fi.hit_bcast;
    hits[wake_pkg::FLG_EXACT]     = fi.hit_exact;
    hits[wake_pkg::FLG_V4]        = fi.hit_v4;
    hits[wake_pkg::FLG_V6]        = fi.hit_v6;
    hits[wake_pkg::FLG_PATTERN]   = fi.hit_pattern;
    hits[wake_pkg::FLG_MAGIC]     = fi.hit_magic;
    hits[wake_pkg::FLG_LINK_UP]   = link_up_event;
    hits[wake_pkg::FLG_LINK_DOWN] = link_down_event;
    hits[wake_pkg::FLG_PIN]       = cur_reg.pin_sync && !cur_reg.pin_last;
    // all enabled conditions of one frame fire together
    fire = (cur_reg.mode == wake_pkg::ST_SLEEP) ? (hits & enables) : 9'h000;
  end

  always_comb
  begin
    cur_next               = cur_reg;
    cur_next.pin_meta      = wake_pin;
    cur_next.pin_sync      = cur_reg.pin_meta;
    cur_next.pin_last      = cur_reg.pin_sync;
    cur_next.remote_wakeup = 1'b0;
    cur_next.keep_valid    = 1'b0;
    cur_next.keep          = 1'b0;
    cur_next.normal_rx     = ~|enables;
    // set wins over a clear in the same cycle
    cur_next.flags = (cur_reg.flags & ~flag_clear) | fire;
    case (cur_reg.mode)
      wake_pkg::ST_RUN:
      begin
        if (suspend_request && wake_pkg::monitored_level(sleep_level))
          cur_next.mode = wake_pkg::ST_SLEEP;
      end
      wake_pkg::ST_SLEEP:
      begin
        if (|fire)
        begin
          cur_next.mode          = wake_pkg::ST_WOKEN;
          cur_next.remote_wakeup = 1'b1;
        end
        else if (resume_request)
          cur_next.mode = wake_pkg::ST_RUN;
      end
      wake_pkg::ST_WOKEN:
      begin
        if (resume_request)
          cur_next.mode = wake_pkg::ST_RUN;
      end
      default:
        cur_next.mode = wake_pkg::ST_RUN;
    endcase
    // registered so the output comes straight from a flip-flop
    cur_next.full_op = (cur_next.mode != wake_pkg::ST_SLEEP);
    if (fi.hit_valid)
    begin
      cur_next.keep_valid = 1'b1;
      // sleeping: only the waking frame and those after it are kept
      cur_next.keep = fi.hit_fcs_ok &&
        ((cur_reg.normal_rx && cur_reg.mode != wake_pkg::ST_SLEEP) ||
         (store_wake_frame && (cur_reg.mode == wake_pkg::ST_WOKEN || |fire)));
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cur_reg.mode          <= wake_pkg::ST_RUN;
      cur_reg.flags         <= wake_pkg::FLAGS_RESET;
      cur_reg.pin_meta      <= 1'b0;
      cur_reg.pin_sync      <= 1'b0;
      cur_reg.pin_last      <= 1'b0;
      cur_reg.remote_wakeup <= 1'b0;
      cur_reg.normal_rx     <= 1'b1;
      cur_reg.full_op       <= 1'b1;
      cur_reg.keep_valid    <= 1'b0;
      cur_reg.keep          <= 1'b0;
    end
    else
      cur_reg <= cur_next;
  end

  assign broadcast_seen_flag  = cur_reg.flags[wake_pkg::FLG_BCAST];
  assign exact_dest_seen_flag = cur_reg.flags[wake_pkg::FLG_EXACT];
  assign v4_syn_seen_flag     = cur_reg.flags[wake_pkg::FLG_V4];
  assign v6_syn_seen_flag     = cur_reg.flags[wake_pkg::FLG_V6];
  assign other_seen_flags     = cur_reg.flags[8:4];
  assign remote_wakeup        = cur_reg.remote_wakeup;
  assign full_operation       = cur_reg.full_op;
  assign normal_rx_enable     = cur_reg.normal_rx;
  assign frame_keep_valid     = cur_reg.keep_valid;
  assign frame_keep           = cur_reg.keep;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sleeping_hit_s(int idx);
    cur_reg.mode == wake_pkg::ST_SLEEP && enables[idx] && hits[idx];
  endsequence

  sequence woke_s(int idx);
    cur_reg.flags[idx] && remote_wakeup && cur_reg.mode == wake_pkg::ST_WOKEN;
  endsequence

  flag_sticky_a: assert property (
    ((~cur_reg.flags & $past(cur_reg.flags)) & ~$past(flag_clear)) == 9'h000)
    else $error("flag dropped without a clear");
  bcast_wake_a: assert property (
    sleeping_hit_s(wake_pkg::FLG_BCAST) |=> woke_s(wake_pkg::FLG_BCAST))
    else $error("broadcast frame did not wake");
  v4_wake_a: assert property (
    sleeping_hit_s(wake_pkg::FLG_V4) |=> woke_s(wake_pkg::FLG_V4))
    else $error("v4 syn did not wake");
  v6_wake_a: assert property (
    sleeping_hit_s(wake_pkg::FLG_V6) |=> woke_s(wake_pkg::FLG_V6))
    else $error("v6 syn did not wake");
  joint_flags_a: assert property (
    sleeping_hit_s(wake_pkg::FLG_BCAST) and sleeping_hit_s(wake_pkg::FLG_EXACT) |=>
    broadcast_seen_flag && exact_dest_seen_flag)
    else $error("joint conditions not flagged together");
  rx_gate_a: assert property (
    (|enables) ##1 (|enables) |-> !normal_rx_enable)
    else $error("normal receive on while an enable is set");
  wake_from_sleep_a: assert property (
    remote_wakeup |-> $past(cur_reg.mode) == wake_pkg::ST_SLEEP &&
    cur_reg.mode == wake_pkg::ST_WOKEN && full_operation)
    else $error("wakeup outside sleep");
  silent_drop_a: assert property (
    fi.hit_valid && !fi.hit_fcs_ok && flag_clear == 9'h000 |=> $stable(cur_reg.flags[5:0]))
    else $error("bad frame changed a flag");
  keep_after_wake_a: assert property (
    cur_reg.mode == wake_pkg::ST_WOKEN && store_wake_frame && fi.hit_valid && fi.hit_fcs_ok
    |=> frame_keep_valid && frame_keep)
    else $error("frame after wake not kept");
endmodule // wake_event_detector

// *** verification/mac_rx_model.sv ***
`timescale 1ns/1ps
package rx_frame_pkg;
  typedef struct packed {
    logic [47:0]  dest;
    logic         v4;
    logic         v6;
    logic         tcp;
    logic         syn;
    logic [127:0] src;
    logic [127:0] dst;
    logic [15:0]  sp;
    logic [15:0]  dp;
    logic         hdr;
    logic         tcpok;
    logic         fcs;
    logic         pat;
  } frame_type;
endpackage

module mac_rx_model (
  input  wire logic               clk,
  input  wire logic               send,
  input  rx_frame_pkg::frame_type spec,
  output logic                    frame_done,
  output rx_frame_pkg::frame_type rx
);
  rx_frame_pkg::frame_type junk = '0;
  // fields outside the done cycle toggle so stale values never pass
  always @(posedge clk) junk <= ~junk;
  assign frame_done = send;
  assign rx         = send ? spec : junk;
endmodule // mac_rx_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic                    clk, rst_n, susp, res, store, bc_en, v4_en, v6_en, lnk, send;
  logic                    lnk_dn, pin;
  logic [1:0]              lvl;
  logic [5:0]              oe;
  logic [8:0]              fclr;
  logic [47:0]             st;
  logic [31:0]             c4s, c4d, c4p, c6p;
  logic [127:0]            c6s, c6d;
  rx_frame_pkg::frame_type spec, rx, g;
  logic                    done, bf, ef, v4f, v6f, rw, fo, nre, kv, keep;
  logic [4:0]              of;
  logic [6:0]              expq[$];
  logic [4:0]              fl;
  int                      mismatches, total_checks;
  bit                      sleeping, woken;
  int                      lv_tab[4] = '{0, 1, 3, 2};

  mac_rx_model partner (.clk(clk), .send(send), .spec(spec), .frame_done(done), .rx(rx));
  wake_event_detector dut (
    .clk(clk), .rst_n(rst_n), .sleep_level(lvl), .suspend_request(susp),
    .resume_request(res), .store_wake_frame(store), .broadcast_wake_enable(bc_en),
    .v4_syn_wake_enable(v4_en), .v6_syn_wake_enable(v6_en), .other_wake_enable(oe),
    .flag_clear(fclr), .station_addr_upper(st[47:32]), .station_addr_lower(st[31:0]),
    .v4_syn_src_compare(c4s), .v4_syn_dst_compare(c4d), .v4_syn_port_compare(c4p),
    .v6_syn_src_compare(c6s), .v6_syn_dst_compare(c6d), .v6_syn_port_compare(c6p),
    .rx_frame_done(done), .rx_dest_addr(rx.dest), .rx_is_ipv4(rx.v4), .rx_is_ipv6(rx.v6),
    .rx_is_tcp(rx.tcp), .rx_tcp_syn(rx.syn), .rx_ip_src(rx.src), .rx_ip_dst(rx.dst),
    .rx_src_port(rx.sp), .rx_dst_port(rx.dp), .rx_ip_hdr_csum_ok(rx.hdr),
    .rx_tcp_csum_ok(rx.tcpok), .rx_fcs_ok(rx.fcs), .rx_pattern_hit(rx.pat),
    .rx_magic_hit(1'b0), .link_up_event(lnk), .link_down_event(lnk_dn), .wake_pin(pin),
    .broadcast_seen_flag(bf), .exact_dest_seen_flag(ef), .v4_syn_seen_flag(v4f),
    .v6_syn_seen_flag(v6f), .other_seen_flags(of), .remote_wakeup(rw),
    .full_operation(fo), .normal_rx_enable(nre), .frame_keep_valid(kv), .frame_keep(keep)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic m(input logic [127:0] w, input logic [127:0] v);
    return (w == 128'h0) || (w == v);
  endfunction

  task automatic frame(input rx_frame_pkg::frame_type f);
    logic b, e, a4, a6, p, q, w, run;
    q   = (f.dest == st) || f.dest[40];
    b   = bc_en && (f.dest == 48'hffff_ffff_ffff);
    e   = oe[0] && (f.dest == st);
    p   = oe[1] && f.pat;
    a4  = v4_en && q && f.v4 && f.tcp && f.syn && f.hdr && f.tcpok && f.fcs &&
          m(c4s, f.src[31:0]) && m(c4d, f.dst[31:0]) && m(c4p, {f.sp, f.dp});
    a6  = v6_en && q && f.v6 && f.tcp && f.syn && f.tcpok && f.fcs &&
          m(c6s, f.src) && m(c6d, f.dst) && m(c6p, {f.sp, f.dp});
    if (!sleeping || !f.fcs)
      {b, e, a4, a6, p} = 5'h00;
    w   = b | e | a4 | a6 | p;
    run = !sleeping && !woken;
    fl  = fl | {b, e, a4, a6, p};
    expq.push_back({fl, w, f.fcs && ((run && !(bc_en | v4_en | v6_en | (|oe))) ||
                                    (store && (woken | w)))});
    if (w)
    begin
      sleeping = 1'b0;
      woken    = 1'b1;
    end
    spec = f;
    send = 1'b1;
    cyc(1);
    send = 1'b0;
    cyc(1);
  endtask

  task automatic suspend(input logic [1:0] l);
    lvl      = l;
    susp     = 1'b1;
    cyc(1);
    susp     = 1'b0;
    sleeping = (l != 2'h2);
    cyc(1);
    chk(8'(!sleeping), 8'(fo));
  endtask

  task automatic wake_clear();
    cyc(3);
    res   = 1'b1;
    cyc(1);
    res      = 1'b0;
    woken    = 1'b0;
    sleeping = 1'b0;
    fclr  = 9'h1ff;
    cyc(1);
    fclr  = 9'h000;
    fl    = 5'h00;
    cyc(1);
    chk(8'h01, {3'h0, bf, ef, v4f, v6f, fo});
  endtask

  task automatic faults(input logic six);
    rx_frame_pkg::frame_type f;
    for (int k = 0; k < 9; k++)
    begin
      f = g;
      case (k)
        0: f.src[0] = ~f.src[0];
        1: f.dst[3] = ~f.dst[3];
        2: f.dp     = ~f.dp;
        3: f.syn    = 1'b0;
        4: f.tcpok  = 1'b0;
        5: f.fcs    = 1'b0;
        6: f.dest   = st ^ 48'h1;
        7:
          if (six)
            f.v6 = 1'b0;
          else
            f.hdr = 1'b0;
        default: f.dest = {8'h01, st[39:0]} | 48'h0100_0000_0000;
      endcase
      frame(f);
    end
    frame(g);
    wake_clear();
  endtask

  always @(negedge clk)
    if (kv === 1'b1)
    begin
      if (expq.size() == 0)
        chk(8'hff, {1'b0, bf, ef, v4f, v6f, of[0], rw, keep});
      else
        chk({1'b0, expq.pop_front()}, {1'b0, bf, ef, v4f, v6f, of[0], rw, keep});
    end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #(8 * 20000);
    mismatches++;
    test_done();
  end

  initial
  begin
    void'($urandom(32'h9374f5f4));
    {rst_n, susp, res, store, bc_en, v4_en, v6_en, lnk, send, lvl, oe, fclr} = '0;
    {c4s, c4d, c4p, c6p, c6s, c6d, spec, fl} = '0;
    {lnk_dn, pin} = 2'b00;
    st     = 48'({$urandom(), $urandom()});
    st[40] = 1'b0;
    cyc(6);
    rst_n  = 1'b1;
    cyc(1);
    chk(8'h06, {bf, ef, v4f, v6f, rw, fo, nre, kv});
    $display("test reset done");
    bc_en = 1'b1;
    cyc(2);
    chk(8'h00, 8'(nre));
    g      = '0;
    g.fcs  = 1'b1;
    g.hdr  = 1'b1;
    g.tcpok = 1'b1;
    foreach (lv_tab[i])
    begin
      suspend(2'(lv_tab[i]));
      g.dest = st;
      frame(g);
      g.dest = 48'hffff_ffff_ffff;
      frame(g);
      cyc(3);
      chk(8'h01, 8'(fo));
      wake_clear();
    end
    $display("test broadcast done");
    store = 1'b1;
    oe    = 6'h03;
    st    = 48'hffff_ffff_ffff;
    suspend(2'h3);
    g.pat = 1'b1;
    frame(g);
    g.pat = 1'b0;
    frame(g);
    wake_clear();
    st     = 48'({$urandom(), $urandom()});
    st[40] = 1'b0;
    oe     = 6'h38;
    suspend(2'h0);
    pin    = 1'b1;
    cyc(2);
    lnk    = 1'b1;
    lnk_dn = 1'b1;
    cyc(1);
    lnk    = 1'b0;
    lnk_dn = 1'b0;
    pin    = 1'b0;
    cyc(2);
    chk(8'h71, {1'b0, of[4:2], 3'h0, fo});
    wake_clear();
    $display("test mixed sources done");
    {bc_en, oe, v4_en} = 8'h01;
    {c4s, c4d, c4p}    = {$urandom() | 32'h1, $urandom() | 32'h1, $urandom() | 32'h10001};
    g = '{dest: st, v4: 1'b1, v6: 1'b0, tcp: 1'b1, syn: 1'b1, src: {96'h0, c4s},
          dst: {96'h0, c4d}, sp: c4p[31:16], dp: c4p[15:0], hdr: 1'b1, tcpok: 1'b1,
          fcs: 1'b1, pat: 1'b0};
    suspend(2'h1);
    faults(1'b0);
    {c4s, c4d, c4p} = '0;
    suspend(2'h3);
    g.src = {$urandom(), $urandom(), $urandom(), $urandom()};
    frame(g);
    wake_clear();
    $display("test v4 syn done");
    {v4_en, v6_en} = 2'b01;
    {c6s, c6d} = {$urandom(), $urandom(), $urandom(), $urandom(), 128'h1};
    c6p  = $urandom() | 32'h10001;
    g.v4 = 1'b0;
    g.v6 = 1'b1;
    {g.src, g.dst, g.sp, g.dp} = {c6s, c6d, c6p};
    suspend(2'h0);
    faults(1'b1);
    $display("test v6 syn done");
    v6_en = 1'b0;
    cyc(2);
    chk(8'h01, 8'(nre));
    chk(8'h00, 8'(expq.size()));
    $display("test enables cleared done");
    test_done();
  end
endmodule // tb_top
